/* File: src/pimg_map.svh */
// Constants of the process image mapper: function codes, windows, fields.
// Included by the package user files; holds definitions only.
`ifndef PIMG_MAP_SVH
`define PIMG_MAP_SVH
`define FC_RD_HOLD     8'h03
`define FC_RD_INPUT    8'h04
`define FC_WR_SINGLE   8'h06
`define FC_WR_MULTI    8'h10
`define FC_RW_MULTI    8'h17
`define FC_ENCAP       8'h2B
`define MEI_OBJ_ACCESS 8'h0D
`define EXC_FLAG       8'h80
`define EXC_FUNC       8'h01
`define EXC_ADDR       8'h02
`define EXC_VALUE      8'h03
`define EXC_FAIL       8'h04
`define OUT_ARR_BASE   16'h07D0
`define IN_ARR_BASE    16'h0BB8
`define TX_IMG_BASE    16'h1388
`define RX_IMG_BASE    16'h1770
`define ARR_REGS       16'h0040
`define IMG_REGS       16'h0020
`define IMG_BYTES      7'h40
`define RX_MAP_OBJ     16'h3502
`define TX_MAP_OBJ     16'h3602
`define MAP_ENTRIES    8'h10
`define FILLER_FIRST   16'h0002
`define FILLER_LAST    16'h0007
`define MAX_RD_QTY     16'h007D
`define MAX_WR_QTY     16'h007B
`define ENT_IDX_LSB    16
`define ENT_SUB_LSB    8
`define ENT_LEN_LSB    0
`define ECHO_WR_LEN    8'h06
`define ECHO_MEI_LEN   8'h0D
`define EXC_LEN        8'h03
`define RD_HDR_LEN     8'h03
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'hA001
`endif

/* File: src/pimg_pkg.sv */
// Types shared by the process image mapper modules.
// Assumes nothing of its surroundings.
package pimg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {S_RX, S_CHECK, S_WRITE, S_UNPACK, S_PACK, S_SEND} state_t;
endpackage

/* File: src/pimg_crc16.sv */
// Byte-wide CRC-16 accumulator, reflected polynomial, Modbus framing.
// Assumes data bytes arrive on the same clock as the strobe.
`timescale 1ns/1ns
`default_nettype none
`include "pimg_map.svh"
module pimg_crc16 (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Byte stream
  input  wire logic          clear,
  input  wire logic          en,
  input  wire pimg_pkg::byte_t data,
  output logic [15:0]        crc
);
  import pimg_pkg::*;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  always_comb begin
    crc_next = crc_reg;
    if (clear) begin
      crc_next = `CRC_INIT;
    end else if (en) begin
      crc_next = crc_reg ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
        crc_next = crc_next[0] ? ((crc_next >> 1) ^ `CRC_POLY) : (crc_next >> 1);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) crc_reg <= `CRC_INIT;
    else        crc_reg <= crc_next;
  end
  assign crc = crc_reg;
endmodule // pimg_crc16
`default_nettype wire

/* File: src/modbus_process_image_mapper.sv */
// Modbus slave process image unit: frame decode, image windows, word arrays.
// Assumes framed request bytes and a reply sink on ref_clk; frame end after last byte.
// Overview of operation
// - Failures answer code 01 function, 02 address, 03 value, 04 failure.
// - Images carry raw mapped values only, no index, subindex or length.
// - Receive and transmit tables, 16 entries each; entry zero holds valid count.
// - Encapsulated object access writes both mapping tables.
// - Mapped values packed back to back in table order, no padding.
// - Filler indices 0002 to 0007 occupy space and always send zero.
// - Receive image starts at holding register 6000.
// - Transmit image starts at register 5000.
// - Image windows served by codes 17, 03, 04, 06 and 10.
// - Zero count disables mapping; entries change only while disabled.
// - Output word array readable from register 2000, never writable.
// - Input word array writable from register 3000, never readable.
// - Word arrays served only by codes 03, 04, 10 and 17.
`timescale 1ns/1ns
`default_nettype none
`include "pimg_map.svh"
module modbus_process_image_mapper #(
  parameter logic [7:0] SLAVE_ADDR = 8'h05,
  parameter int         BUF_DEPTH  = 256
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  // Request frame in
  input  wire pimg_pkg::byte_t rx_byte,
  input  wire logic            rx_valid,
  input  wire logic            rx_end,
  output logic                 busy,
  // Reply frame out
  output pimg_pkg::byte_t      tx_byte,
  output logic                 tx_valid,
  output logic                 tx_last,
  input  wire logic            tx_ready,
  // Object values
  output logic [15:0]          od_rd_index,
  output logic [7:0]           od_rd_sub,
  input  wire logic [31:0]     od_rd_data,
  output logic                 od_wr,
  output logic [15:0]          od_wr_index,
  output logic [7:0]           od_wr_sub,
  output logic [31:0]          od_wr_data,
  // Program side of the word arrays
  input  wire logic            out_wr,
  input  wire logic [4:0]      out_idx,
  input  wire logic [31:0]     out_data,
  input  wire logic [4:0]      in_idx,
  output logic [31:0]          in_data
);
  import pimg_pkg::*;
  byte_t       buf_mem [BUF_DEPTH];
  logic [31:0] in_mem [32];
  logic [31:0] out_mem [32];
  byte_t       rx_img [64];
  byte_t       tx_img [64];
  logic [31:0] rx_map [16];
  logic [31:0] tx_map [16];
  logic [4:0]  rx_cnt_reg, tx_cnt_reg;
  state_t      state_reg, state_next;
  logic [8:0]  len_reg, len_next;
  logic        ovf_reg, ovf_next, exc_reg, exc_next, echo_reg, echo_next;
  logic        upk_reg, upk_next, pck_reg, pck_next;
  byte_t       code_reg, code_next, rlen_reg, rlen_next, k_reg, k_next;
  byte_t       dpos_reg, dpos_next, wcnt_reg, wcnt_next;
  logic [15:0] rs_reg, rs_next, rq_reg, rq_next, ws_reg, ws_next, wq_reg, wq_next;
  logic [4:0]  e_reg, e_next;
  logic [2:0]  j_reg, j_next;
  logic [6:0]  p_reg, p_next, txlen_reg, txlen_next;
  logic [31:0] acc_reg, acc_next;
  byte_t       txb_next;
  logic        txv_next, txl_next, odw_next;
  logic [15:0] odi_next;
  logic [7:0]  ods_next;
  logic [31:0] odd_next;
  byte_t       ecode, fc, rbyte, bc_rd;
  logic [15:0] a23, a45, a67, a89, wa, ra, mei_obj, roff, woff, oa, iwa;
  logic [7:0]  mei_sub, bi, d;
  logic [31:0] mei_val, ent, ow;
  logic [15:0] sel16;
  logic [15:0] crc_rx, crc_tx;
  logic [4:0]  cnt;
  logic [2:0]  nb;
  logic        frame_ok, fc_known, do_rd, do_wr, map_we, buf_we, wr_we, txi_we;
  logic        walk_done, last_b, filler, load, crc_tx_en;
  function automatic logic win(input logic [15:0] s, q, base, n);
    win = (s >= base) && (({1'b0, s} + {1'b0, q}) <= ({1'b0, base} + {1'b0, n}));
  endfunction
  assign fc       = buf_mem[1];
  assign a23      = {buf_mem[2], buf_mem[3]};
  assign a45      = {buf_mem[4], buf_mem[5]};
  assign a67      = {buf_mem[6], buf_mem[7]};
  assign a89      = {buf_mem[8], buf_mem[9]};
  assign mei_obj  = a67;
  assign mei_sub  = buf_mem[8];
  assign mei_val  = {buf_mem[16], buf_mem[15], buf_mem[14], buf_mem[13]};
  assign frame_ok = (len_reg >= 9'h004) && (crc_rx == 16'h0000) && (buf_mem[0] == SLAVE_ADDR);
  assign fc_known = fc inside {`FC_RD_HOLD, `FC_RD_INPUT, `FC_WR_SINGLE, `FC_WR_MULTI,
                               `FC_RW_MULTI, `FC_ENCAP};
  assign busy     = (state_reg != S_RX);
  // The walker reads the receive table while unpacking and the transmit table while packing.
  assign ent      = (state_reg == S_PACK) ? tx_map[e_reg[3:0]] : rx_map[e_reg[3:0]];
  assign cnt      = (state_reg == S_PACK) ? tx_cnt_reg : rx_cnt_reg;
  assign nb       = (ent[`ENT_LEN_LSB+:8] >= 8'h20) ? 3'h4 : 3'(ent[`ENT_LEN_LSB+:8] >> 3);
  assign last_b   = (j_reg + 3'h1) >= nb;
  assign filler   = (ent[`ENT_IDX_LSB+:16] >= `FILLER_FIRST) &&
                    (ent[`ENT_IDX_LSB+:16] <= `FILLER_LAST);
  assign walk_done   = ({3'h0, e_reg} >= {3'h0, cnt}) || (p_reg >= `IMG_BYTES);
  assign od_rd_index = ent[`ENT_IDX_LSB+:16];
  assign od_rd_sub   = ent[`ENT_SUB_LSB+:8];
  // Write side: one register per cycle out of the request buffer.
  assign wa   = ws_reg + {8'h00, wcnt_reg};
  assign bi   = 8'(dpos_reg + {wcnt_reg[6:0], 1'b0});
  assign iwa  = wa - `IN_ARR_BASE;
  assign woff = 16'((wa - `RX_IMG_BASE) << 1);
  // Read side: reply data byte d belongs to register ra, high byte first.
  assign d     = k_reg - `RD_HDR_LEN;
  assign ra    = rs_reg + {9'h000, d[7:1]};
  assign roff  = 16'((ra - `TX_IMG_BASE) << 1) | {15'h0000, d[0]};
  assign oa    = ra - `OUT_ARR_BASE;
  assign ow    = out_mem[oa[5:1]];
  assign sel16 = oa[0] ? ow[15:0] : ow[31:16];
  assign bc_rd = 8'({rq_reg[14:0], 1'b0});
  assign load  = !tx_valid || tx_ready;
  always_comb begin
    if (exc_reg) begin
      unique case (k_reg)
        8'h00:   rbyte = buf_mem[0];
        8'h01:   rbyte = fc | `EXC_FLAG;
        default: rbyte = code_reg;
      endcase
    end else if (echo_reg) begin
      rbyte = buf_mem[k_reg];
    end else if (k_reg < `RD_HDR_LEN) begin
      rbyte = (k_reg == 8'h02) ? bc_rd : buf_mem[k_reg];
    end else if (ra >= `TX_IMG_BASE) begin
      rbyte = (roff < {9'h000, txlen_reg}) ? tx_img[roff[5:0]] : 8'h00;
    end else begin
      rbyte = d[0] ? sel16[7:0] : sel16[15:8];
    end
  end
  always_comb begin
    state_next = state_reg; len_next = len_reg; ovf_next = ovf_reg;
    exc_next = exc_reg; echo_next = echo_reg; code_next = code_reg;
    upk_next = upk_reg; pck_next = pck_reg; rlen_next = rlen_reg; k_next = k_reg;
    dpos_next = dpos_reg; wcnt_next = wcnt_reg; rs_next = rs_reg; rq_next = rq_reg;
    ws_next = ws_reg; wq_next = wq_reg; e_next = e_reg; j_next = j_reg; p_next = p_reg;
    txlen_next = txlen_reg; acc_next = acc_reg; txb_next = tx_byte; txv_next = tx_valid;
    txl_next = tx_last; odw_next = 1'b0; odi_next = od_wr_index; ods_next = od_wr_sub;
    odd_next = od_wr_data; ecode = 8'h00; do_rd = 1'b0; do_wr = 1'b0; map_we = 1'b0;
    buf_we = 1'b0; wr_we = 1'b0; txi_we = 1'b0; crc_tx_en = 1'b0;
    unique case (state_reg)
      S_RX: begin
        if (rx_valid) begin
          if (len_reg == 9'(BUF_DEPTH)) ovf_next = 1'b1;
          else begin
            buf_we = 1'b1;
            len_next = len_reg + 9'h001;
          end
        end
        if (rx_end) state_next = S_CHECK;
      end
      S_CHECK: begin
        len_next = 9'h000; ovf_next = 1'b0; k_next = 8'h00; wcnt_next = 8'h00;
        e_next = 5'h00; j_next = 3'h0; p_next = 7'h00; acc_next = 32'h0;
        echo_next = 1'b0; state_next = S_RX;
        rs_next = a23; rq_next = a45; ws_next = a23; wq_next = 16'h0001; dpos_next = 8'h04;
        rlen_next = 8'(`RD_HDR_LEN + {a45[6:0], 1'b0});
        if (ovf_reg) ecode = `EXC_FAIL;
        else begin
          unique case (fc)
            `FC_RD_HOLD, `FC_RD_INPUT: begin
              if (a45 == 16'h0 || a45 > `MAX_RD_QTY) ecode = `EXC_VALUE;
              else if (!win(a23, a45, `OUT_ARR_BASE, `ARR_REGS) &&
                       !win(a23, a45, `TX_IMG_BASE, `IMG_REGS)) ecode = `EXC_ADDR;
              else do_rd = 1'b1;
            end
            `FC_WR_SINGLE: begin
              echo_next = 1'b1; rlen_next = `ECHO_WR_LEN;
              if (win(a23, 16'h0001, `RX_IMG_BASE, `IMG_REGS)) do_wr = 1'b1;
              else if (win(a23, 16'h0001, `IN_ARR_BASE, `ARR_REGS) ||
                       win(a23, 16'h0001, `OUT_ARR_BASE, `ARR_REGS)) ecode = `EXC_FUNC;
              else ecode = `EXC_ADDR;
            end
            `FC_WR_MULTI, `FC_RW_MULTI: begin
              if (fc == `FC_RW_MULTI) begin
                ws_next = a67; wq_next = a89; dpos_next = 8'h0B;
              end else begin
                wq_next = a45; dpos_next = 8'h07; echo_next = 1'b1; rlen_next = `ECHO_WR_LEN;
              end
              if (wq_next == 16'h0 || wq_next > `MAX_WR_QTY ||
                  buf_mem[dpos_next - 8'h01] != 8'({wq_next[6:0], 1'b0}) ||
                  len_reg != 9'(dpos_next) + 9'(buf_mem[dpos_next - 8'h01]) + 9'h002 ||
                  (fc == `FC_RW_MULTI && (a45 == 16'h0 || a45 > `MAX_RD_QTY)))
                ecode = `EXC_VALUE;
              else if ((!win(ws_next, wq_next, `IN_ARR_BASE, `ARR_REGS) &&
                        !win(ws_next, wq_next, `RX_IMG_BASE, `IMG_REGS)) ||
                       (fc == `FC_RW_MULTI && !win(a23, a45, `OUT_ARR_BASE, `ARR_REGS) &&
                        !win(a23, a45, `TX_IMG_BASE, `IMG_REGS))) ecode = `EXC_ADDR;
              else begin
                do_wr = 1'b1;
                do_rd = (fc == `FC_RW_MULTI);
              end
            end
            `FC_ENCAP: begin
              echo_next = 1'b1; rlen_next = `ECHO_MEI_LEN;
              if (buf_mem[2] != `MEI_OBJ_ACCESS || !buf_mem[3][7]) ecode = `EXC_FUNC;
              else if (mei_obj != `RX_MAP_OBJ && mei_obj != `TX_MAP_OBJ) ecode = `EXC_ADDR;
              else if (mei_sub > `MAP_ENTRIES) ecode = `EXC_ADDR;
              else if (mei_sub == 8'h00 && mei_val > 32'(`MAP_ENTRIES)) ecode = `EXC_VALUE;
              else if (mei_sub != 8'h00 &&
                       ((mei_obj == `TX_MAP_OBJ) ? tx_cnt_reg : rx_cnt_reg) != 5'h00)
                ecode = `EXC_VALUE;
              else map_we = 1'b1;
            end
            default: ecode = `EXC_FUNC;
          endcase
        end
        exc_next = (ecode != 8'h00);
        code_next = ecode;
        upk_next = do_wr && (ws_next >= `RX_IMG_BASE);
        pck_next = do_rd && (a23 >= `TX_IMG_BASE);
        if (frame_ok) begin
          if (ecode != 8'h00) begin
            rlen_next = `EXC_LEN;
            state_next = S_SEND;
          end else if (do_wr) state_next = S_WRITE;
          else if (pck_next) state_next = S_PACK;
          else state_next = S_SEND;
        end
      end
      S_WRITE: begin
        wr_we = 1'b1;
        wcnt_next = wcnt_reg + 8'h01;
        if (wcnt_reg == 8'(wq_reg - 16'h0001))
          state_next = upk_reg ? S_UNPACK : (pck_reg ? S_PACK : S_SEND);
      end
      S_UNPACK, S_PACK: begin
        if (walk_done) begin
          e_next = 5'h00; j_next = 3'h0; p_next = 7'h00;
          if (state_reg == S_PACK) begin
            txlen_next = p_reg;
            state_next = S_SEND;
          end else state_next = pck_reg ? S_PACK : S_SEND;
        end else if (nb == 3'h0) begin
          e_next = e_reg + 5'h01;
        end else begin
          p_next = p_reg + 7'h01;
          j_next = last_b ? 3'h0 : j_reg + 3'h1;
          e_next = last_b ? e_reg + 5'h01 : e_reg;
          if (state_reg == S_PACK) txi_we = 1'b1;
          else begin
            acc_next = last_b ? 32'h0 : acc_reg | (32'(rx_img[p_reg[5:0]]) << {j_reg, 3'h0});
            if (last_b && !filler) begin
              odw_next = 1'b1;
              odi_next = ent[`ENT_IDX_LSB+:16];
              ods_next = ent[`ENT_SUB_LSB+:8];
              odd_next = acc_reg | (32'(rx_img[p_reg[5:0]]) << {j_reg, 3'h0});
            end
          end
        end
      end
      S_SEND: begin
        if (load) begin
          if (k_reg <= rlen_reg + 8'h01) begin
            txv_next = 1'b1;
            txl_next = (k_reg == rlen_reg + 8'h01);
            k_next = k_reg + 8'h01;
            crc_tx_en = (k_reg < rlen_reg);
            txb_next = (k_reg < rlen_reg) ? rbyte :
                       ((k_reg == rlen_reg) ? crc_tx[7:0] : crc_tx[15:8]);
          end else begin
            txv_next = 1'b0;
            txl_next = 1'b0;
            state_next = S_RX;
          end
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_RX; len_reg <= 9'h000; ovf_reg <= 1'b0; exc_reg <= 1'b0;
      echo_reg <= 1'b0; code_reg <= 8'h00; upk_reg <= 1'b0; pck_reg <= 1'b0;
      rlen_reg <= 8'h00; k_reg <= 8'h00; dpos_reg <= 8'h00; wcnt_reg <= 8'h00;
      rs_reg <= 16'h0; rq_reg <= 16'h0; ws_reg <= 16'h0; wq_reg <= 16'h0;
      e_reg <= 5'h00; j_reg <= 3'h0; p_reg <= 7'h00; txlen_reg <= 7'h00; acc_reg <= 32'h0;
      tx_byte <= 8'h00; tx_valid <= 1'b0; tx_last <= 1'b0; od_wr <= 1'b0;
      od_wr_index <= 16'h0; od_wr_sub <= 8'h00; od_wr_data <= 32'h0;
    end else begin
      state_reg <= state_next; len_reg <= len_next; ovf_reg <= ovf_next; exc_reg <= exc_next;
      echo_reg <= echo_next; code_reg <= code_next; upk_reg <= upk_next; pck_reg <= pck_next;
      rlen_reg <= rlen_next; k_reg <= k_next; dpos_reg <= dpos_next; wcnt_reg <= wcnt_next;
      rs_reg <= rs_next; rq_reg <= rq_next; ws_reg <= ws_next; wq_reg <= wq_next;
      e_reg <= e_next; j_reg <= j_next; p_reg <= p_next; txlen_reg <= txlen_next;
      acc_reg <= acc_next; tx_byte <= txb_next; tx_valid <= txv_next; tx_last <= txl_next;
      od_wr <= odw_next; od_wr_index <= odi_next; od_wr_sub <= ods_next; od_wr_data <= odd_next;
    end
  end
  // Storage arrays carry no reset; a zero count and zero image length keep the mapping tables and images unread.
  always_ff @(posedge ref_clk) begin
    if (buf_we) buf_mem[len_reg[7:0]] <= rx_byte;
    if (out_wr) out_mem[out_idx] <= out_data;
    if (wr_we && wa >= `RX_IMG_BASE) begin
      rx_img[woff[5:0]] <= buf_mem[bi];
      rx_img[woff[5:0] + 6'h01] <= buf_mem[bi + 8'h01];
    end else if (wr_we) begin
      if (iwa[0]) in_mem[iwa[5:1]][15:0]  <= {buf_mem[bi], buf_mem[bi + 8'h01]};
      else        in_mem[iwa[5:1]][31:16] <= {buf_mem[bi], buf_mem[bi + 8'h01]};
    end
    if (txi_we) tx_img[p_reg[5:0]] <= filler ? 8'h00 : 8'(od_rd_data >> {j_reg, 3'h0});
    if (map_we && mei_sub != 8'h00) begin
      if (mei_obj == `TX_MAP_OBJ) tx_map[4'(mei_sub - 8'h01)] <= mei_val;
      else                        rx_map[4'(mei_sub - 8'h01)] <= mei_val;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_reg <= 5'h00; tx_cnt_reg <= 5'h00; in_data <= 32'h0;
    end else begin
      in_data <= in_mem[in_idx];
      if (map_we && mei_sub == 8'h00) begin
        if (mei_obj == `TX_MAP_OBJ) tx_cnt_reg <= mei_val[4:0];
        else                        rx_cnt_reg <= mei_val[4:0];
      end
    end
  end
  // Every byte of the frame enters the check, stored or not, so an overlong frame still answers.
  pimg_crc16 u_crc_rx (.ref_clk(ref_clk), .rst_n(rst_n), .clear(state_reg == S_CHECK),
    .en(state_reg == S_RX && rx_valid), .data(rx_byte), .crc(crc_rx));
  pimg_crc16 u_crc_tx (.ref_clk(ref_clk), .rst_n(rst_n), .clear(state_reg == S_CHECK),
    .en(crc_tx_en), .data(rbyte), .crc(crc_tx));
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_check(logic [7:0] f);
    state_reg == S_CHECK && frame_ok && !ovf_reg && fc == f;
  endsequence
  sequence s_exc_load;
    state_reg == S_SEND && exc_reg && load && k_reg == 8'h01;
  endsequence
  chk_bad_func: assert property (state_reg == S_CHECK && frame_ok && !ovf_reg && !fc_known
    |=> exc_reg && code_reg == `EXC_FUNC) else $error("unknown function not refused");
  chk_array_single: assert property (s_check(`FC_WR_SINGLE) ##0
    win(a23, 16'h0001, `IN_ARR_BASE, `ARR_REGS) |=> code_reg == `EXC_FUNC)
    else $error("single write reached word array");
  chk_out_readonly: assert property (state_reg == S_WRITE |->
    !win(wa, 16'h0001, `OUT_ARR_BASE, `ARR_REGS)) else $error("output array written");
  chk_in_writeonly: assert property (state_reg == S_SEND && !exc_reg && !echo_reg &&
    k_reg >= `RD_HDR_LEN && k_reg < rlen_reg |-> !win(ra, 16'h0001, `IN_ARR_BASE, `ARR_REGS))
    else $error("input array read");
  chk_count_guard: assert property (s_check(`FC_ENCAP) ##0 (buf_mem[2] == `MEI_OBJ_ACCESS &&
    buf_mem[3][7] && mei_obj == `TX_MAP_OBJ && mei_sub == 8'h01 && tx_cnt_reg != 5'h00)
    |=> code_reg == `EXC_VALUE && tx_map[0] == $past(tx_map[0]))
    else $error("entry changed while mapping enabled");
  chk_filler_zero: assert property (state_reg == S_PACK && !walk_done && nb != 3'h0 && filler
    |=> tx_img[$past(p_reg[5:0])] == 8'h00) else $error("filler byte not zero");
  chk_pack_seq: assert property (state_reg == S_PACK && !walk_done && nb != 3'h0
    |=> p_reg == $past(p_reg) + 7'h01) else $error("image gap in packing");
  chk_exc_frame: assert property (s_exc_load |=> tx_valid && tx_byte == (fc | `EXC_FLAG)
    ##1 (tx_byte == code_reg || !$past(tx_ready)))
    else $error("exception reply malformed");
  chk_rx_base: assert property (state_reg == S_WRITE && wa == `RX_IMG_BASE
    |=> rx_img[0] == $past(buf_mem[bi])) else $error("receive image base wrong");
  chk_map_write: assert property (map_we && mei_obj == `TX_MAP_OBJ && mei_sub == 8'h01
    |=> tx_map[0] == $past(mei_val)) else $error("mapping entry not stored");
endmodule // modbus_process_image_mapper
`default_nettype wire

/* File: verif/modbus_master_model.sv */
// Modbus master model: sends framed requests and collects the reply bytes.
// Assumes the mapper takes one byte per cycle and answers on ref_clk.
`timescale 1ns/1ns
`default_nettype none
module modbus_master_model (
  // Clock
  input  wire logic            ref_clk,
  // Request out
  output pimg_pkg::byte_t      rx_byte,
  output logic                 rx_valid,
  output logic                 rx_end,
  // Reply in
  input  wire pimg_pkg::byte_t tx_byte,
  input  wire logic            tx_valid,
  input  wire logic            tx_last,
  output logic                 tx_ready
);
  import pimg_pkg::*;
  byte_t reply[$];
  logic  done = 1'b0;
  logic  slow = 1'b0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
  end
  function automatic logic [15:0] crc16(input byte_t f[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Appends the checksum low byte first, then marks the frame end two cycles after the last byte.
  task automatic send(input byte_t f[$]);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge ref_clk) #1;
      rx_byte = f[i];
      rx_valid = 1'b1;
    end
    @(posedge ref_clk) #1;
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    @(posedge ref_clk) #1;
    rx_end = 1'b1;
    @(posedge ref_clk) #1;
    rx_end = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    if (rx_end) begin
      reply.delete();
      done <= 1'b0;
    end
    if (tx_valid && tx_ready) begin
      reply.push_back(tx_byte);
      if (tx_last) done <= 1'b1;
    end
    #1 tx_ready = slow ? ~tx_ready : 1'b1;
  end
endmodule // modbus_master_model
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench: function codes, windows and exceptions of the mapper.
// Assumes the master model above and one 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pimg_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, rxv, rxe, txv, txl, txr, odw, outw = 1'b0;
  byte_t rxb, txb;
  logic [15:0] rdi, wri;
  logic [7:0] rds, wrs;
  logic [31:0] wrd, ind, outd = 32'h0;
  logic [4:0] outi = 5'h00, ini = 5'h00;
  int miscompares = 0, comparisons = 0;
  int od_pulses = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (odw) od_pulses <= od_pulses + 1;
  modbus_master_model i_mst (.ref_clk(ref_clk), .rx_byte(rxb), .rx_valid(rxv), .rx_end(rxe),
    .tx_byte(txb), .tx_valid(txv), .tx_last(txl), .tx_ready(txr));
  modbus_process_image_mapper i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .rx_byte(rxb),
    .rx_valid(rxv), .rx_end(rxe), .busy(), .tx_byte(txb), .tx_valid(txv), .tx_last(txl),
    .tx_ready(txr), .od_rd_index(rdi), .od_rd_sub(rds), .od_rd_data({rdi, rds, 8'h5A}),
    .od_wr(odw), .od_wr_index(wri), .od_wr_sub(wrs), .od_wr_data(wrd), .out_wr(outw),
    .out_idx(outi), .out_data(outd), .in_idx(ini), .in_data(ind));
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // Sends a request and compares the whole reply, checksum included.
  task automatic xfer(input byte_t q[$], input byte_t e[$]);
    logic [15:0] c;
    i_mst.send(q);
    for (int i = 0; i < 3000 && !i_mst.done; i++) @(posedge ref_clk);
    if (!i_mst.done) begin
      check("reply timeout", 1, 0);
      results();
    end
    c = i_mst.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check("reply length", e.size(), i_mst.reply.size());
    foreach (e[i]) check("reply byte", e[i], i_mst.reply[i]);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_arrays();
    @(posedge ref_clk) #1;
    outw = 1'b1;
    outd = 32'hA1B2C3D4;
    @(posedge ref_clk) #1;
    outw = 1'b0;
    i_mst.slow = 1'b1;
    xfer('{8'h05, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h02}, '{8'h05, 8'h03, 8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
    i_mst.slow = 1'b0;
    xfer('{8'h05, 8'h10, 8'h07, 8'hD0, 8'h00, 8'h02, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, '{8'h05, 8'h90, 8'h02});
    xfer('{8'h05, 8'h10, 8'h0B, 8'hB8, 8'h00, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44}, '{8'h05, 8'h10, 8'h0B, 8'hB8, 8'h00, 8'h02});
    @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    check("input word", 32'h11223344, ind);
    xfer('{8'h05, 8'h04, 8'h0B, 8'hB8, 8'h00, 8'h01}, '{8'h05, 8'h84, 8'h02});
    xfer('{8'h05, 8'h06, 8'h0B, 8'hB8, 8'h00, 8'h01}, '{8'h05, 8'h86, 8'h01});
    xfer('{8'h05, 8'h17, 8'h07, 8'hD0, 8'h00, 8'h02, 8'h0B, 8'hB8, 8'h00, 8'h02, 8'h04,
           8'h55, 8'h66, 8'h77, 8'h88}, '{8'h05, 8'h17, 8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
    @(posedge ref_clk) #1;
    check("combined input word", 32'h55667788, ind);
  endtask
  task automatic t_image_map();
    xfer('{8'h05, 8'h41, 8'h00, 8'h00}, '{8'h05, 8'hC1, 8'h01});
    xfer('{8'h05, 8'h04, 8'h13, 8'h88, 8'h00, 8'h02}, '{8'h05, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    xfer('{8'h05, 8'h2B, 8'h0D, 8'h80, 8'h00, 8'h00, 8'h36, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00}, '{8'h05, 8'hAB, 8'h03});
  endtask
  // Writes one mapping entry; a nonzero code is the exception that must come back.
  task automatic map_wr(input byte_t obj, input byte_t sub, input logic [31:0] v,
                        input byte_t code);
    byte_t q[$], e[$];
    q = '{8'h05, 8'h2B, 8'h0D, 8'h80, 8'h00, 8'h00, obj, 8'h02, sub, 8'h00, 8'h00, 8'h00,
          8'h00};
    e = q;
    if (code != 8'h00) e = '{8'h05, 8'hAB, code};
    q.push_back(v[7:0]);
    q.push_back(v[15:8]);
    q.push_back(v[23:16]);
    q.push_back(v[31:24]);
    xfer(q, e);
  endtask
  // Tables are filled while their counts are zero, then enabled by writing the count.
  task automatic t_mapping();
    map_wr(8'h36, 8'h01, 32'h12345610, 8'h00);
    map_wr(8'h36, 8'h02, 32'h00050008, 8'h00);
    map_wr(8'h36, 8'h00, 32'h00000002, 8'h00);
    map_wr(8'h36, 8'h01, 32'h00000000, 8'h03);
    xfer('{8'h05, 8'h04, 8'h13, 8'h88, 8'h00, 8'h02},
         '{8'h05, 8'h04, 8'h04, 8'h5A, 8'h56, 8'h00, 8'h00});
    map_wr(8'h35, 8'h01, 32'h22220110, 8'h00);
    map_wr(8'h35, 8'h00, 32'h00000001, 8'h00);
    xfer('{8'h05, 8'h06, 8'h17, 8'h70, 8'hAB, 8'hCD},
         '{8'h05, 8'h06, 8'h17, 8'h70, 8'hAB, 8'hCD});
    check("object pulses", 1, od_pulses);
    check("object index", 32'h00222201, {8'h00, wri, wrs});
    check("object value", 32'h0000CDAB, wrd);
  endtask
  // A frame longer than the buffer still checks clean and earns the failure code.
  task automatic t_overflow();
    byte_t q[$];
    q = '{8'h05, 8'h03};
    repeat (255) q.push_back(8'h00);
    xfer(q, '{8'h05, 8'h83, 8'h04});
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_arrays();
    t_image_map();
    t_mapping();
    t_overflow();
    results();
  end
endmodule // testbench
`default_nettype wire
